// file: design/pll_core.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Reference divide ratio from 3-bit select: 8,128,256,512,1024,2048,2410,8192.
// - Open select and divide inputs read as logic one.
// - Divide-by-N counter reloads programmed value plus offset, minus one, at zero count.
// - Divide value is 14-bit unsigned, bit 0 least significant.
// - Receive select low adds offset 856; high or open adds nothing.
// - N counter counts frequency input; its terminal count is divided feedback.
// - Reference divider counts reference oscillator input into divided reference.
// - Three-state output: low when feedback leads, high when lags, else off.
// - Feedback leading pulses feedback-side output low; reference side stays high.
// - Feedback lagging pulses reference-side output low; feedback side stays high.
// - Locked: both outputs high except brief simultaneous minimum low pulse.
// - Divided feedback is brought out on its own pin.
// - Lock indicator high when locked, pulses low out of lock.
module pll_core #(
    parameter int DIV_W     = pll_core_pkg::DIV_W,
    parameter int REF_CNT_W = pll_core_pkg::REF_CNT_W
) (
    input  wire logic                                CLK,
    input  wire logic                                RST,
    input  wire logic                                FREQ_IN,
    input  wire logic                                REF_OSC_INPUT,
    input  wire logic [pll_core_pkg::REF_SEL_W-1:0]  REF_RATIO_SELECT,
    input  wire logic [DIV_W-1:0]                    DIVIDE_VALUE_BITS,
    input  wire logic                                TX_RX_SELECT,
    output logic                                     DIVIDED_FEEDBACK,
    output logic                                     DIVIDED_REFERENCE,
    output logic                                     TRISTATE_ERROR_OUT,
    output logic                                     TRISTATE_ERROR_OE,
    output pll_core_pkg::dual_err_t                  DUAL_ERR,
    output logic                                     LOCK_INDICATOR
);

    logic                 fin_q;
    logic                 ref_q;
    logic                 fin_rise;
    logic                 ref_rise;
    logic [DIV_W-1:0]     n_cnt_q;
    logic [DIV_W-1:0]     n_load;
    logic [REF_CNT_W-1:0] r_cnt_q;
    logic [REF_CNT_W-1:0] r_load;
    logic                 fv_q;
    logic                 fr_q;
    logic                 up_q;
    logic                 down_q;
    logic [1:0]           both_cnt_q;
    logic                 lock_q;
    pll_core_pkg::pd_state_t pd_state;

    function automatic logic [REF_CNT_W-1:0] ref_ratio(input logic [2:0] sel);
        case (sel)
            3'h0:    ref_ratio = pll_core_pkg::REF_DIV_0;
            3'h1:    ref_ratio = pll_core_pkg::REF_DIV_1;
            3'h2:    ref_ratio = pll_core_pkg::REF_DIV_2;
            3'h3:    ref_ratio = pll_core_pkg::REF_DIV_3;
            3'h4:    ref_ratio = pll_core_pkg::REF_DIV_4;
            3'h5:    ref_ratio = pll_core_pkg::REF_DIV_5;
            3'h6:    ref_ratio = pll_core_pkg::REF_DIV_6;
            default: ref_ratio = pll_core_pkg::REF_DIV_7;
        endcase
    endfunction : ref_ratio

    // The 8192 ratio exceeds 13 bits, so code 7 stores 8191 and the counter
    // is loaded with ratio minus one for the other codes to keep one period.
    always_comb begin
        r_load = ref_ratio(REF_RATIO_SELECT);
        if (REF_RATIO_SELECT != 3'h7) begin
            r_load = r_load - 13'h0001;
        end
    end

    // Inputs default high when open; pull-ups are modelled at the pads.
    // A value plus offset beyond the counter width wraps, so the programming
    // side must keep the sum in range.
    always_comb begin
        n_load = DIVIDE_VALUE_BITS;
        if (!TX_RX_SELECT) begin
            n_load = DIVIDE_VALUE_BITS + pll_core_pkg::TX_OFFSET;
        end
        n_load = n_load - 14'h0001;
    end

    // The edge flops carry no reset: they always hold the previous input level,
    // so an input already high when reset ends is not taken as a rising edge.
    always_ff @(posedge CLK) begin
        fin_q <= FREQ_IN;
        ref_q <= REF_OSC_INPUT;
    end

    assign fin_rise = FREQ_IN && !fin_q;
    assign ref_rise = REF_OSC_INPUT && !ref_q;

    // The edge that finds the count at zero reloads N minus one and flags one
    // output pulse, so each output period spans N input edges.
    always_ff @(posedge CLK) begin
        if (RST) begin
            n_cnt_q <= '0;
            fv_q    <= 1'b0;
        end else begin
            fv_q <= 1'b0;
            if (fin_rise) begin
                if (n_cnt_q == '0) begin
                    n_cnt_q <= n_load;
                    fv_q    <= 1'b1;
                end else begin
                    n_cnt_q <= n_cnt_q - 14'h0001;
                end
            end
        end
    end

    // The select code is read only at each reload, so a new ratio takes effect
    // from the period that follows the change.
    always_ff @(posedge CLK) begin
        if (RST) begin
            r_cnt_q <= '0;
            fr_q    <= 1'b0;
        end else begin
            fr_q <= 1'b0;
            if (ref_rise) begin
                if (r_cnt_q == '0) begin
                    r_cnt_q <= r_load;
                    fr_q    <= 1'b1;
                end else begin
                    r_cnt_q <= r_cnt_q - 13'h0001;
                end
            end
        end
    end

    // Phase-frequency detector: feedback edge sets down, reference edge sets
    // up; when both are set they hold a minimum width, then clear together.
    always_ff @(posedge CLK) begin
        if (RST) begin
            up_q   <= 1'b0;
            down_q <= 1'b0;
        end else if (up_q && down_q && both_cnt_q >= pll_core_pkg::MIN_PULSE_CYC) begin
            up_q   <= fr_q;
            down_q <= fv_q;
        end else begin
            if (fv_q) begin
                down_q <= 1'b1;
            end
            if (fr_q) begin
                up_q <= 1'b1;
            end
        end
    end

    // Counts the cycles for which both sides have stood active; the pair is
    // released once this count reaches the minimum coincidence width.
    always_ff @(posedge CLK) begin
        if (RST) begin
            both_cnt_q <= 2'h0;
        end else if (up_q && down_q) begin
            if (both_cnt_q < pll_core_pkg::MIN_PULSE_CYC) begin
                both_cnt_q <= both_cnt_q + 2'h1;
            end else begin
                both_cnt_q <= 2'h0;
            end
        end else begin
            both_cnt_q <= 2'h0;
        end
    end

    // Decodes the two pending flags into one detector state.
    always_comb begin
        case ({up_q, down_q})
            2'b01:   pd_state = pll_core_pkg::PD_DOWN;
            2'b10:   pd_state = pll_core_pkg::PD_UP;
            2'b11:   pd_state = pll_core_pkg::PD_BOTH;
            default: pd_state = pll_core_pkg::PD_IDLE;
        endcase
    end

    // The single-ended pin is driven only while one side alone is active;
    // idle and coincidence both leave it undriven.
    always_comb begin
        TRISTATE_ERROR_OUT = 1'b0;
        TRISTATE_ERROR_OE  = 1'b0;
        case (pd_state)
            pll_core_pkg::PD_DOWN: begin
                TRISTATE_ERROR_OUT = 1'b0;
                TRISTATE_ERROR_OE  = 1'b1;
            end
            pll_core_pkg::PD_UP: begin
                TRISTATE_ERROR_OUT = 1'b1;
                TRISTATE_ERROR_OE  = 1'b1;
            end
            default: begin
                TRISTATE_ERROR_OUT = 1'b0;
                TRISTATE_ERROR_OE  = 1'b0;
            end
        endcase
    end

    assign DUAL_ERR.lead_n = !down_q;
    assign DUAL_ERR.lag_n  = !up_q;

    // Lock drops in the cycle after exactly one side is active, which excludes the
    // simultaneous minimum-width pulse of a locked loop.
    always_ff @(posedge CLK) begin
        if (RST) begin
            lock_q <= 1'b1;
        end else begin
            lock_q <= !(up_q ^ down_q);
        end
    end

    // The divided feedback pin carries the same pulse that feeds the detector.
    assign LOCK_INDICATOR    = lock_q;
    assign DIVIDED_FEEDBACK  = fv_q;
    assign DIVIDED_REFERENCE = fr_q;

endmodule : pll_core

`default_nettype wire

// file: design/pll_core_pkg.sv
package pll_core_pkg;

    localparam int REF_SEL_W  = 3;
    localparam int DIV_W      = 14;
    localparam int REF_CNT_W  = 13;

    localparam logic [DIV_W-1:0] TX_OFFSET = 14'h0358;

    localparam logic [REF_CNT_W-1:0] REF_DIV_0 = 13'h0008;
    localparam logic [REF_CNT_W-1:0] REF_DIV_1 = 13'h0080;
    localparam logic [REF_CNT_W-1:0] REF_DIV_2 = 13'h0100;
    localparam logic [REF_CNT_W-1:0] REF_DIV_3 = 13'h0200;
    localparam logic [REF_CNT_W-1:0] REF_DIV_4 = 13'h0400;
    localparam logic [REF_CNT_W-1:0] REF_DIV_5 = 13'h0800;
    localparam logic [REF_CNT_W-1:0] REF_DIV_6 = 13'h096a;
    localparam logic [REF_CNT_W-1:0] REF_DIV_7 = 13'h1fff;

    localparam logic [1:0] MIN_PULSE_CYC = 2'h1;

    typedef struct packed {
        logic lead_n;
        logic lag_n;
    } dual_err_t;

    typedef enum logic [1:0] {
        PD_IDLE = 2'b00,
        PD_UP   = 2'b01,
        PD_DOWN = 2'b10,
        PD_BOTH = 2'b11
    } pd_state_t;

endpackage : pll_core_pkg

// file: tb/pll_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pll_core_monitor (
    input wire logic                    CLK,
    input wire logic                    RST,
    input wire logic                    DIVIDED_FEEDBACK,
    input wire logic                    DIVIDED_REFERENCE,
    input wire logic                    TRISTATE_ERROR_OUT,
    input wire logic                    TRISTATE_ERROR_OE,
    input wire pll_core_pkg::dual_err_t DUAL_ERR,
    input wire logic                    LOCK_INDICATOR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic a;
    logic b;
    assign a = DUAL_ERR.lead_n;
    assign b = DUAL_ERR.lag_n;
    sequence s_idle; a && b; endsequence
    sequence s_both; !a && !b; endsequence
    AST_LEAD_LOW: assert property (!a && b |-> TRISTATE_ERROR_OE && !TRISTATE_ERROR_OUT)
        else $error("lead state not driving low");
    AST_LAG_HIGH: assert property (a && !b |-> TRISTATE_ERROR_OE && TRISTATE_ERROR_OUT)
        else $error("lag state not driving high");
    AST_COINC_Z: assert property (a == b |-> !TRISTATE_ERROR_OE)
        else $error("pin driven without error");
    AST_FB_LEAD: assert property (s_idle ##0 DIVIDED_FEEDBACK && !DIVIDED_REFERENCE
        |=> !a && b)
        else $error("feedback pulse did not set lead");
    AST_REF_LAG: assert property (s_idle ##0 DIVIDED_REFERENCE && !DIVIDED_FEEDBACK
        |=> a && !b)
        else $error("reference pulse did not set lag");
    AST_COINC: assert property (!a && !b && ($past(a) || $past(b)) |=> s_both ##1 s_idle)
        else $error("coincidence pulse width wrong");
    AST_LOCK: assert property (1'b1 |=> LOCK_INDICATOR == ($past(a) ~^ $past(b)))
        else $error("lock indicator wrong");
    AST_FB_ONE: assert property (DIVIDED_FEEDBACK |=> !DIVIDED_FEEDBACK)
        else $error("feedback pulse too long");
    AST_REF_ONE: assert property (DIVIDED_REFERENCE |=> !DIVIDED_REFERENCE)
        else $error("reference pulse too long");
endmodule : pll_core_monitor
bind pll_core pll_core_monitor pll_core_monitor_inst (.CLK(CLK), .RST(RST),
    .DIVIDED_FEEDBACK(DIVIDED_FEEDBACK), .DIVIDED_REFERENCE(DIVIDED_REFERENCE),
    .TRISTATE_ERROR_OUT(TRISTATE_ERROR_OUT), .TRISTATE_ERROR_OE(TRISTATE_ERROR_OE),
    .DUAL_ERR(DUAL_ERR), .LOCK_INDICATOR(LOCK_INDICATOR));
`default_nettype wire

// file: tb/pll_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pll_core_tb_top;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    en_fb = 1'b0;
    logic                    en_ref = 1'b0;
    logic                    fin;
    logic                    rin;
    logic [2:0]              sel = 3'h0;
    logic [13:0]             nval = 14'h0003;
    logic                    tx = 1'b1;
    logic                    dfb;
    logic                    dref;
    logic                    pout;
    logic                    poe;
    pll_core_pkg::dual_err_t derr;
    logic                    lock;
    int                      error_cnt = 0;
    int                      n_tests = 0;
    logic [15:0]             ref_exp [8] = '{16'h0010, 16'h0100, 16'h0200, 16'h0400,
                                             16'h0800, 16'h1000, 16'h12d4, 16'h4000};
    always #2 clk = ~clk;
    pll_stim_src pll_stim_src_inst (.CLK(clk), .en_fb(en_fb), .en_ref(en_ref),
        .FREQ_IN(fin), .REF_OSC_INPUT(rin));
    pll_core pll_core_inst (.CLK(clk), .RST(rst), .FREQ_IN(fin), .REF_OSC_INPUT(rin),
        .REF_RATIO_SELECT(sel), .DIVIDE_VALUE_BITS(nval), .TX_RX_SELECT(tx),
        .DIVIDED_FEEDBACK(dfb), .DIVIDED_REFERENCE(dref), .TRISTATE_ERROR_OUT(pout),
        .TRISTATE_ERROR_OE(poe), .DUAL_ERR(derr), .LOCK_INDICATOR(lock));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, exp, got);
        end
    endtask : chk
    // Waits for the selected divided pulse, counting cycles from the next edge on.
    task automatic wait_sel(input logic r, output logic [15:0] cyc);
        cyc = 16'h0001;
        @(negedge clk);
        while ((r ? dref : dfb) !== 1'b1 && cyc < 16'h9000) begin
            @(negedge clk);
            cyc++;
        end
    endtask : wait_sel
    task automatic period(input logic r, output logic [15:0] cyc);
        wait_sel(r, cyc);
        wait_sel(r, cyc);
    endtask : period
    task automatic t_ref_ratios();
        logic [15:0] c;
        en_fb <= 1'b0;
        en_ref <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            sel = i[2:0];
            period(1'b1, c);
            chk(ref_exp[i], c);
        end
        en_ref <= 1'b0;
        @(negedge clk);
    endtask : t_ref_ratios
    task automatic t_div(input logic [13:0] n, input logic t, input logic [15:0] exp);
        logic [15:0] c;
        nval = n;
        tx = t;
        en_fb <= 1'b1;
        period(1'b0, c);
        chk(exp, c);
        en_fb <= 1'b0;
        @(negedge clk);
    endtask : t_div
    task automatic t_detector();
        logic [15:0] c;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        nval = 14'h0003;
        tx = 1'b1;
        sel = 3'h0;
        en_fb <= 1'b1;
        wait_sel(1'b0, c);
        en_fb <= 1'b0;
        repeat (3) @(negedge clk);
        chk(16'h000c, {11'h000, derr.lead_n, derr.lag_n, poe, pout, lock});
        en_ref <= 1'b1;
        wait_sel(1'b1, c);
        @(negedge clk);
        chk(16'h0000, {13'h0000, derr.lead_n, derr.lag_n, poe});
        wait_sel(1'b1, c);
        chk(16'h000d, {12'h000, derr.lead_n, derr.lag_n, poe, lock});
        repeat (3) @(negedge clk);
        chk(16'h0016, {11'h000, derr.lead_n, derr.lag_n, poe, pout, lock});
        en_ref <= 1'b0;
    endtask : t_detector
    initial begin
        #400us;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_div(14'h0005, 1'b1, 16'h000a);
        t_div(14'h0105, 1'b1, 16'h020a);
        t_div(14'h0003, 1'b0, 16'h06b6);
        t_ref_ratios();
        t_detector();
        report_and_stop();
    end
endmodule : pll_core_tb_top
`default_nettype wire

// file: tb/pll_stim_src.sv
`timescale 1ns/1ps
`default_nettype none
module pll_stim_src (
    input  wire logic CLK,
    input  wire logic en_fb,
    input  wire logic en_ref,
    output logic      FREQ_IN,
    output logic      REF_OSC_INPUT
);
    // Both sources toggle at the fastest legal rate and stand low when off.
    initial begin
        FREQ_IN       = 1'b0;
        REF_OSC_INPUT = 1'b0;
        forever begin
            @(negedge CLK);
            FREQ_IN       <= en_fb & ~FREQ_IN;
            REF_OSC_INPUT <= en_ref & ~REF_OSC_INPUT;
        end
    end
endmodule : pll_stim_src
`default_nettype wire
